//--- hw/ipc_pkg.sv
// Package: register map, field positions, reset values and types of the interrupt priority control block
package ipc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] IPC_ADDR_PRIO   = 8'hB8;
    localparam logic [7:0] IPC_ADDR_ENABLE = 8'hA8;
    localparam logic [7:0] IPC_ADDR_STATUS = 8'hC0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IPC_NUM_SRC    = 6;
    localparam int IPC_BIT_EXT0   = 0;
    localparam int IPC_BIT_TIMER0 = 1;
    localparam int IPC_BIT_EXT1   = 2;
    localparam int IPC_BIT_TIMER1 = 3;
    localparam int IPC_BIT_RSVD   = 6;
    localparam int IPC_BIT_BYPASS = 7;
    localparam int IPC_BIT_GATE   = 7;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] IPC_PRIO_RESET   = 8'h00;
    localparam logic [7:0] IPC_ENABLE_RESET = 8'h00;
    localparam logic [1:0] IPC_RESP_OKAY    = 2'h0;
    localparam logic [1:0] IPC_RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       level;
        logic [2:0] index;
    } ipc_offer_type;

    typedef enum logic [1:0] {
        IPC_IDLE = 2'b00,
        IPC_LOW  = 2'b01,
        IPC_HIGH = 2'b10,
        IPC_NEST = 2'b11
    } ipc_svc_type;
endpackage

//--- hw/ipc_arbiter.sv
// Module: picks the next interrupt to offer from pending sources and their levels
`timescale 1ns/100ps
module ipc_arbiter (
    input  wire logic [ipc_pkg::IPC_NUM_SRC-1:0] pending,
    input  wire logic [ipc_pkg::IPC_NUM_SRC-1:0] highSel,
    input  wire logic                            highBusy,
    input  wire logic                            anyBusy,
    output ipc_pkg::ipc_offer_type               offer
);
    import ipc_pkg::*;

    logic [IPC_NUM_SRC-1:0] hiPend;
    logic [IPC_NUM_SRC-1:0] loPend;

    // Split pending requests by level
    genvar g;
    generate
        for (g = 0; g < IPC_NUM_SRC; g++) begin : gSplit
            assign hiPend[g] = pending[g] & highSel[g];
            assign loPend[g] = pending[g] & ~highSel[g];
        end
    endgenerate

    // High may interrupt low service; low waits for all service to end
    always_comb begin
        offer = '0;
        for (int i = IPC_NUM_SRC - 1; i >= 0; i--) begin
            if (!anyBusy && loPend[i]) begin
                offer.valid = 1'b1;
                offer.level = 1'b0;
                offer.index = 3'(i);
            end
        end
        // Lowest index wins inside a level, high level overrides
        for (int i = IPC_NUM_SRC - 1; i >= 0; i--) begin
            if (!highBusy && hiPend[i]) begin
                offer.valid = 1'b1;
                offer.level = 1'b1;
                offer.index = 3'(i);
            end
        end
    end
endmodule

//--- hw/ipc_top.sv
// Module: interrupt priority control with AXI4-Lite register access
//
// Notes on behaviour
// - Priority bit 1 set puts timer 0 at high level, clear at low.
// - Priority bit 2 set puts external interrupt 1 at high level.
// - Priority bit 3 set puts timer 1 at high level.
// - Bypass bit clear: priority bits apply and high-level requests are served as such.
// - Bypass bit set: priority bits ignored, only enable register gates requests.
// - Global gate bit clear blocks every interrupt regardless of other settings.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
module ipc_top (
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    input  wire logic [31:0]                     s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [31:0]                     s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic [ipc_pkg::IPC_NUM_SRC-1:0] irqSrc,
    input  wire logic                            irqAck,
    input  wire logic                            irqDone,
    output logic                                 irqReq,
    output logic                                 irqHigh,
    output logic [2:0]                           irqIndex
);
    import ipc_pkg::*;

    logic [7:0]             prio_r;
    logic [7:0]             enable_r;
    ipc_svc_type            svc_r;
    ipc_svc_type            svc_nxt;
    ipc_offer_type          offer_r;
    ipc_offer_type          offer_nxt;
    logic [IPC_NUM_SRC-1:0] highSel;
    logic [IPC_NUM_SRC-1:0] pending;
    logic                   bypass;
    logic                   wrFire;
    logic                   arFire;
    logic                   ackFire;
    logic [7:0]             wrAddr;
    logic [7:0]             rdAddr;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rdata_r;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Both write channels taken together; simpler than buffering one of them
    assign wrFire        = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wrFire;
    assign s_axi_wready  = wrFire;
    assign arFire        = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign wrAddr        = s_axi_awaddr[7:0];
    assign rdAddr        = s_axi_araddr[7:0];
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // Register writes, byte lane 0 only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prio_r   <= IPC_PRIO_RESET;
            enable_r <= IPC_ENABLE_RESET;
        end else if (wrFire && s_axi_wstrb[0] && s_axi_awaddr[31:8] == 24'h00_0000) begin
            if (wrAddr == IPC_ADDR_PRIO) begin
                prio_r <= s_axi_wdata[7:0];
            end
            if (wrAddr == IPC_ADDR_ENABLE) begin
                enable_r <= s_axi_wdata[7:0];
            end
        end
    end

    // Write response, status register is read-only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= IPC_RESP_OKAY;
        end else if (wrFire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (s_axi_awaddr[31:8] == 24'h00_0000 &&
                         (wrAddr == IPC_ADDR_PRIO || wrAddr == IPC_ADDR_ENABLE)) ? IPC_RESP_OKAY : IPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data; reserved bit 6 reads as one in both control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rresp_r  <= IPC_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (arFire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= IPC_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
            if (s_axi_araddr[31:8] != 24'h00_0000) begin
                rresp_r <= IPC_RESP_SLVERR;
            end else if (rdAddr == IPC_ADDR_PRIO) begin
                rdata_r[7:0]        <= prio_r;
                rdata_r[IPC_BIT_RSVD] <= 1'b1;
            end else if (rdAddr == IPC_ADDR_ENABLE) begin
                rdata_r[7:0]        <= enable_r;
                rdata_r[IPC_BIT_RSVD] <= 1'b1;
            end else if (rdAddr == IPC_ADDR_STATUS) begin
                // Service state on top, offer below; bit 3 unused so the index sits at the bottom
                rdata_r[7:0] <= {svc_r, offer_r.valid, offer_r.level, 1'b0, offer_r.index};
            end else begin
                rresp_r <= IPC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Level selection and gating
    // ------------------------------------------------------------
    // Bypass stops the priority circuit: every source falls to one level
    assign bypass  = prio_r[IPC_BIT_BYPASS];
    assign highSel = bypass ? '0 : prio_r[IPC_NUM_SRC-1:0];
    // Global gate and per-source enables decide what is pending
    assign pending = irqSrc & enable_r[IPC_NUM_SRC-1:0] & {IPC_NUM_SRC{enable_r[IPC_BIT_GATE]}};

    // ------------------------------------------------------------
    // Service nesting state
    // ------------------------------------------------------------
    assign ackFire = irqAck && offer_r.valid;

    // Two nesting levels: a high service may sit on top of a low one
    always_comb begin
        svc_nxt = svc_r;
        case (svc_r)
            IPC_IDLE: begin
                if (ackFire) begin
                    svc_nxt = offer_r.level ? IPC_HIGH : IPC_LOW;
                end
            end
            IPC_LOW: begin
                if (ackFire && offer_r.level) begin
                    svc_nxt = IPC_NEST;
                end else if (irqDone) begin
                    svc_nxt = IPC_IDLE;
                end
            end
            IPC_HIGH: begin
                if (irqDone) begin
                    svc_nxt = IPC_IDLE;
                end
            end
            IPC_NEST: begin
                if (irqDone) begin
                    svc_nxt = IPC_LOW;
                end
            end
            default: svc_nxt = IPC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            svc_r <= IPC_IDLE;
        end else begin
            svc_r <= svc_nxt;
        end
    end

    // Arbiter sees next service state so an accepted offer is not repeated
    ipc_arbiter uArb (
        .pending  (pending),
        .highSel  (highSel),
        .highBusy (svc_nxt == IPC_HIGH || svc_nxt == IPC_NEST),
        .anyBusy  (svc_nxt != IPC_IDLE),
        .offer    (offer_nxt)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            offer_r <= '0;
        end else begin
            offer_r <= offer_nxt;
        end
    end

    assign irqReq   = offer_r.valid;
    assign irqHigh  = offer_r.level;
    assign irqIndex = offer_r.index;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_timer0_level: assert property (@(posedge clk) disable iff (sys_rst)
        offer_nxt.valid && offer_nxt.index == 3'(IPC_BIT_TIMER0) |=> irqHigh == (!$past(bypass) && $past(prio_r[1])))
        else $error("timer 0 offered at wrong level");
    a_ext1_level: assert property (@(posedge clk) disable iff (sys_rst)
        offer_nxt.valid && offer_nxt.index == 3'(IPC_BIT_EXT1) |=> irqHigh == (!$past(bypass) && $past(prio_r[2])))
        else $error("external 1 offered at wrong level");
    a_timer1_level: assert property (@(posedge clk) disable iff (sys_rst)
        offer_nxt.valid && offer_nxt.index == 3'(IPC_BIT_TIMER1) |=> irqHigh == (!$past(bypass) && $past(prio_r[3])))
        else $error("timer 1 offered at wrong level");
    a_high_offered: assert property (@(posedge clk) disable iff (sys_rst)
        !bypass && |(pending & highSel) && svc_nxt != IPC_HIGH && svc_nxt != IPC_NEST |=> irqReq && irqHigh)
        else $error("pending high request not offered");
    a_bypass_flat: assert property (@(posedge clk) disable iff (sys_rst)
        $past(bypass) && bypass |-> !irqHigh && svc_r != IPC_NEST)
        else $error("priority level used while bypassed");
    a_gate_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        !enable_r[IPC_BIT_GATE] |=> !irqReq)
        else $error("request offered with global gate closed");
    a_low_waits: assert property (@(posedge clk) disable iff (sys_rst)
        svc_r != IPC_IDLE && svc_nxt != IPC_IDLE |=> !(irqReq && !irqHigh))
        else $error("low request offered during service");
    a_high_preempts: assert property (@(posedge clk) disable iff (sys_rst)
        svc_r == IPC_LOW && ackFire && offer_r.level && !irqDone |=>
            svc_r == IPC_NEST ##1 (svc_r == IPC_NEST || irqDone || svc_r == IPC_LOW))
        else $error("high request did not nest over low service");
endmodule

//--- sim/ipc_core_model.sv
// Partner model: core that takes offered interrupts and returns from service
`timescale 1ns/100ps
module ipc_core_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic irqReq,
    input  wire logic ackEn,
    input  wire logic doneReq,
    output logic      irqAck,
    output logic      irqDone
);
    // One-cycle ack pulse, so a standing offer is never taken twice
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqAck  <= 1'b0;
            irqDone <= 1'b0;
        end else begin
            irqAck  <= ackEn && irqReq && !irqAck;
            irqDone <= doneReq;
        end
    end
endmodule

//--- sim/test_interrupt_priority_control.sv
// Testbench: register access, offer selection and preemption
`timescale 1ns/100ps
module test_interrupt_priority_control;
    import ipc_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ackEn = 1'b0, doneReq = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [5:0]  irqSrc = '0, s;
    logic        irqAck, irqDone, irqReq, irqHigh;
    logic [2:0]  irqIndex;
    logic [7:0]  pr, en;
    logic [7:0]  cPr [6] = '{8'h02, 8'h04, 8'h08, 8'h88, 8'h3F, 8'h00};
    logic [7:0]  cEn [6] = '{8'h8F, 8'h8F, 8'h8F, 8'h8F, 8'h3F, 8'hBF};
    logic [5:0]  cSrc [6] = '{6'h03, 6'h05, 6'h09, 6'h09, 6'h3F, 6'h30};
    int          failures = 0;
    int          compares = 0;

    ipc_top i_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irqSrc(irqSrc), .irqAck(irqAck), .irqDone(irqDone), .irqReq(irqReq), .irqHigh(irqHigh),
        .irqIndex(irqIndex));
    ipc_core_model i_core (.clk(clk), .sys_rst(sys_rst), .irqReq(irqReq), .ackEn(ackEn),
        .doneReq(doneReq), .irqAck(irqAck), .irqDone(irqDone));

    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A wait that used up its bound ends the run
    task automatic guard(input int n);
        if (n >= 64) begin
            failures++;
            $display("BAD wait expected answer seen timeout");
            wrap_up();
        end
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr  <= {24'h00_0000, a};
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (s_axi_awready !== 1'b1 && n < 64);
        guard(n);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (s_axi_bvalid !== 1'b1 && n < 64);
        guard(n);
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr  <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (s_axi_arready !== 1'b1 && n < 64);
        guard(n);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (s_axi_rvalid !== 1'b1 && n < 64);
        guard(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Expected {req, high, index}: high level first, lowest index within a level
    function automatic logic [4:0] expOffer(input logic [7:0] p, input logic [7:0] e, input logic [5:0] q);
        logic [5:0] pend;
        logic [5:0] hs;
        logic [4:0] r;
        pend = q & e[5:0] & {6{e[7]}};
        hs = pend & (p[7] ? 6'h00 : p[5:0]);
        r = 5'h00;
        for (int i = 5; i >= 0; i--) if (pend[i]) r = {2'b10, 3'(i)};
        for (int i = 5; i >= 0; i--) if (hs[i]) r = {2'b11, 3'(i)};
        return r;
    endfunction

    task automatic chkOffer(input logic [4:0] e);
        chk("offer", {27'h0, irqReq, irqReq ? {irqHigh, irqIndex} : 4'h0}, {27'h0, e});
    endtask

    task automatic pulseDone();
        doneReq <= 1'b1;
        @(posedge clk);
        doneReq <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h69bc_9875));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        axiRead(IPC_ADDR_PRIO, rd, rs);
        chk("prio reset", rd, 32'h0000_0040);
        axiRead(IPC_ADDR_ENABLE, rd, rs);
        chk("enable reset", rd, 32'h0000_0040);
        axiRead(8'h10, rd, rs);
        chk("unmapped read", {30'h0, rs}, {30'h0, IPC_RESP_SLVERR});
        axiWrite(IPC_ADDR_STATUS, 8'h00, IPC_RESP_SLVERR);
        $display("test registers done");
        // Corner settings first, then random ones
        for (int t = 0; t < 40; t++) begin
            pr = (t < 6) ? cPr[t] : 8'($urandom);
            en = (t < 6) ? cEn[t] : 8'($urandom);
            s  = (t < 6) ? cSrc[t] : 6'($urandom);
            axiWrite(IPC_ADDR_PRIO, pr, IPC_RESP_OKAY);
            axiWrite(IPC_ADDR_ENABLE, en, IPC_RESP_OKAY);
            irqSrc <= s;
            repeat (3) @(posedge clk);
            chkOffer(expOffer(pr, en, s));
            axiRead(IPC_ADDR_PRIO, rd, rs);
            chk("prio readback", rd, {24'h0, pr[7], 1'b1, pr[5:0]});
        end
        $display("test selection done");
        // Low service, then a high request preempts it and low waits
        axiWrite(IPC_ADDR_PRIO, 8'h02, IPC_RESP_OKAY);
        axiWrite(IPC_ADDR_ENABLE, 8'h8F, IPC_RESP_OKAY);
        irqSrc <= 6'h01;
        ackEn <= 1'b1;
        repeat (5) @(posedge clk);
        ackEn <= 1'b0;
        axiRead(IPC_ADDR_STATUS, rd, rs);
        chk("service low", {30'h0, rd[7:6]}, 32'h1);
        irqSrc <= 6'h05;
        repeat (3) @(posedge clk);
        chkOffer(5'h00);
        irqSrc <= 6'h07;
        repeat (3) @(posedge clk);
        chkOffer(5'h19);
        ackEn <= 1'b1;
        repeat (5) @(posedge clk);
        ackEn <= 1'b0;
        axiRead(IPC_ADDR_STATUS, rd, rs);
        chk("service nested", {30'h0, rd[7:6]}, 32'h3);
        irqSrc <= 6'h04;
        pulseDone();
        repeat (3) @(posedge clk);
        chkOffer(5'h00);
        pulseDone();
        repeat (3) @(posedge clk);
        chkOffer(5'h12);
        $display("test preemption done");
        wrap_up();
    end
endmodule
